// ===== src/dsf_status_top.v
// board status flag registers with timer request and sequence done events
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "dsf_defs.vh"
module dsf_status_top #(
   parameter CAL_CYCLES = `DSF_CAL_CYCLES,
   parameter MODE_BITS  = 3
) (
   input  wire                 mclk_i,
   input  wire                 rst_b_i,
   input  wire [`DSF_AW-1:0]   addr_i,
   input  wire [15:0]          wdata_i,
   input  wire                 wr_i,
   input  wire                 rd_i,
   output reg  [15:0]          rdata_o,
   output reg                  irq_o,
   input  wire                 timer_tick_i,
   input  wire                 dac_write_i,
   input  wire                 seq_running_i,
   input  wire                 seq_end_i,
   input  wire                 fifo_full_i,
   input  wire                 fifo_half_i,
   input  wire                 fifo_empty_i,
   input  wire                 cfg_mem_empty_i,
   input  wire                 adc_converting_i,
   input  wire                 cal_rom_select_cmd_i,
   input  wire                 sclk_i,
   input  wire                 sdata_in_i,
   input  wire [MODE_BITS-1:0] legal_mode_i,
   input  wire                 rom_sdo_i,
   output reg                  rom_cs_o,
   output reg                  out_data_req_o,
   output reg                  cal_start_o,
   output reg                  adc_busy_n_o
);
   reg                   rst_s1_q;
   reg                   rst_s2_q;
   reg [2:0]             mode_q;
   reg [`DSF_IRQ_W-1:0]  irq_stat_q;
   reg [`DSF_IRQ_W-1:0]  irq_mask_q;
   reg                   timer_request_flag_q;
   reg                   output_sequence_done_q;
   reg                   seq_end_q;
   reg [`DSF_IRQ_W-1:0]  ev;
   reg [15:0]            status_one;
   reg [15:0]            rd_d;
   wire                  rst_n = rst_s2_q;
   wire                  cal_busy;
   wire                  cal_done;
   wire                  rom_cs;
   wire                  rom_data;
   wire                  out_fifo_not_full   = ~fifo_full_i;
   wire                  out_fifo_below_half = ~fifo_half_i;
   wire                  out_fifo_not_empty  = ~fifo_empty_i;
   wire                  chan_cfg_not_empty  = ~cfg_mem_empty_i;
   wire                  dma_mode = mode_q[`DSF_BIT_MODE_DMA];
   wire wr_tmr = wr_i && addr_i == `DSF_OFF_TMR_CLR;
   wire wr_dac = wr_i && addr_i == `DSF_OFF_DAC_CLR;
   wire wr_cal = wr_i && addr_i == `DSF_OFF_CAL_STROBE;
   wire ready_for_data = out_fifo_not_full & out_fifo_below_half;
   wire tmr_set = mode_q[`DSF_BIT_MODE_DACEN] & ready_for_data & timer_tick_i;

   always @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end

   dsf_cal_timer #(
      .CAL_CYCLES (CAL_CYCLES)
   ) u_cal (
      .mclk_i  (mclk_i),
      .rst_b_i (rst_n),
      .start_i (wr_cal),
      .busy_o  (cal_busy),
      .done_o  (cal_done)
   );

   dsf_rom_guard #(
      .MODE_BITS (MODE_BITS)
   ) u_rom (
      .mclk_i               (mclk_i),
      .rst_b_i              (rst_n),
      .cal_rom_select_cmd_i (cal_rom_select_cmd_i),
      .sclk_i               (sclk_i),
      .sdata_in_i           (sdata_in_i),
      .legal_mode_i         (legal_mode_i),
      .rom_sdo_i            (rom_sdo_i),
      .rom_cs_o             (rom_cs),
      .rom_data_o           (rom_data)
   );

   always @* begin
      ev = {`DSF_IRQ_W{1'b0}};
      ev[`DSF_IRQ_TMR] = tmr_set;
      ev[`DSF_IRQ_SEQ] = seq_end_i & ~seq_end_q;
      ev[`DSF_IRQ_CAL] = cal_done;
   end

   always @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         mode_q                 <= `DSF_MODE_RST;
         irq_mask_q             <= `DSF_MASK_RST;
         irq_stat_q             <= {`DSF_IRQ_W{1'b0}};
         timer_request_flag_q   <= 1'b0;
         output_sequence_done_q <= 1'b0;
         seq_end_q              <= 1'b0;
      end else begin
         seq_end_q <= seq_end_i;
         if (wr_i && addr_i == `DSF_OFF_MODE)
            mode_q <= wdata_i[2:0];
         if (wr_i && addr_i == `DSF_OFF_IRQ_MASK)
            irq_mask_q <= wdata_i[`DSF_IRQ_W-1:0];
         // set wins over a clear in the same cycle
         if (tmr_set)
            timer_request_flag_q <= 1'b1;
         else if (!dma_mode && wr_tmr)
            timer_request_flag_q <= 1'b0;
         else if (dma_mode && dac_write_i)
            timer_request_flag_q <= 1'b0;
         if (seq_running_i)
            output_sequence_done_q <= 1'b0;
         else if (seq_end_i)
            output_sequence_done_q <= 1'b1;
         begin : stat_upd
            reg [`DSF_IRQ_W-1:0] clr;
            clr = {`DSF_IRQ_W{1'b0}};
            if (wr_i && addr_i == `DSF_OFF_IRQ_STAT)
               clr = wdata_i[`DSF_IRQ_W-1:0];
            if (wr_tmr || wr_dac)
               clr[`DSF_IRQ_SEQ] = 1'b1;
            if (wr_tmr)
               clr[`DSF_IRQ_TMR] = 1'b1;
            irq_stat_q <= (irq_stat_q & ~clr) | ev;
         end
      end
   end

   always @* begin
      status_one = 16'h0;
      status_one[`DSF_BIT_TMR_REQ]    = timer_request_flag_q;
      status_one[`DSF_BIT_SEQ_DONE]   = output_sequence_done_q;
      status_one[`DSF_BIT_NOT_FULL]   = out_fifo_not_full;
      status_one[`DSF_BIT_BELOW_HALF] = out_fifo_below_half;
      status_one[`DSF_BIT_NOT_EMPTY]  = out_fifo_not_empty;
      status_one[`DSF_BIT_ROM_DATA]   = rom_data;
      // the registered pin copy, so the bit matches what the rom really sees
      status_one[`DSF_BIT_ROM_DESEL]  = rom_cs_o;
      status_one[`DSF_BIT_CFG_NEMPTY] = chan_cfg_not_empty;
      rd_d = 16'h0;
      case (addr_i)
         `DSF_OFF_STATUS_ONE: rd_d = status_one;
         `DSF_OFF_ADC_BUSY:   rd_d = {15'h0, ~(adc_converting_i | cal_busy)};
         `DSF_OFF_MODE:       rd_d = {13'h0, mode_q};
         `DSF_OFF_IRQ_STAT:   rd_d = {13'h0, irq_stat_q};
         `DSF_OFF_IRQ_MASK:   rd_d = {13'h0, irq_mask_q};
         default:             rd_d = 16'h0;
      endcase
   end

   always @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         rdata_o        <= 16'h0;
         irq_o          <= 1'b0;
         rom_cs_o       <= 1'b0;
         out_data_req_o <= 1'b0;
         cal_start_o    <= 1'b0;
         adc_busy_n_o   <= 1'b1;
      end else begin
         rdata_o <= rd_i ? rd_d : 16'h0;
         // level irq; mode irq enable gates the done event too
         irq_o <= |(irq_stat_q & irq_mask_q) & mode_q[`DSF_BIT_MODE_IRQEN];
         rom_cs_o <= rom_cs;
         // requests hold while the timer request flag is set, dac enable is on and the fifo is not full
         out_data_req_o <= timer_request_flag_q & out_fifo_not_full &
                           mode_q[`DSF_BIT_MODE_DACEN];
         cal_start_o  <= wr_cal;
         adc_busy_n_o <= ~(adc_converting_i | cal_busy);
      end
   end
endmodule
`default_nettype wire

// ===== src/dsf_defs.vh
// constants for the board status flag block
`ifndef DSF_DEFS_VH
`define DSF_DEFS_VH
`define DSF_AW              5
`define DSF_OFF_STATUS_ONE  5'h18
`define DSF_OFF_ADC_BUSY    5'h1a
`define DSF_OFF_TMR_CLR     5'h02
`define DSF_OFF_DAC_CLR     5'h04
`define DSF_OFF_CAL_STROBE  5'h06
`define DSF_OFF_MODE        5'h0a
`define DSF_OFF_IRQ_STAT    5'h0c
`define DSF_OFF_IRQ_MASK    5'h0e
`define DSF_BIT_TMR_REQ     7
`define DSF_BIT_SEQ_DONE    6
`define DSF_BIT_NOT_FULL    5
`define DSF_BIT_BELOW_HALF  4
`define DSF_BIT_NOT_EMPTY   3
`define DSF_BIT_ROM_DATA    2
`define DSF_BIT_ROM_DESEL   1
`define DSF_BIT_CFG_NEMPTY  0
`define DSF_BIT_MODE_DMA    0
`define DSF_BIT_MODE_IRQEN  1
`define DSF_BIT_MODE_DACEN  2
`define DSF_IRQ_W           3
`define DSF_IRQ_TMR         0
`define DSF_IRQ_SEQ         1
`define DSF_IRQ_CAL         2
`define DSF_MODE_RST        3'h0
`define DSF_MASK_RST        3'h0
`define DSF_CLK_HZ          40000000
`define DSF_CAL_TIME_MS     1250
`define DSF_CAL_CYCLES      ((`DSF_CLK_HZ / 1000) * `DSF_CAL_TIME_MS)
`endif

// ===== src/dsf_cal_timer.v
// self-calibration busy timer
`timescale 1ns/1ps
`default_nettype none
module dsf_cal_timer #(
   parameter CAL_CYCLES = 50000000
) (
   input  wire mclk_i,
   input  wire rst_b_i,
   input  wire start_i,
   output reg  busy_o,
   output reg  done_o
);
   reg [31:0] cnt_q;

   always @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cnt_q  <= 32'h0;
         busy_o <= 1'b0;
         done_o <= 1'b0;
      end else begin
         done_o <= 1'b0;
         // a restart while busy begins the full interval again
         if (start_i) begin
            cnt_q  <= CAL_CYCLES[31:0] - 32'h1;
            busy_o <= 1'b1;
         end else if (busy_o) begin
            if (cnt_q == 32'h0) begin
               busy_o <= 1'b0;
               done_o <= 1'b1;
            end else begin
               cnt_q <= cnt_q - 32'h1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ===== src/dsf_rom_guard.v
// calibration rom select protection and serial data capture
`timescale 1ns/1ps
`default_nettype none
module dsf_rom_guard #(
   parameter MODE_BITS = 3
) (
   input  wire mclk_i,
   input  wire rst_b_i,
   input  wire cal_rom_select_cmd_i,
   input  wire sclk_i,
   input  wire sdata_in_i,
   input  wire [MODE_BITS-1:0] legal_mode_i,
   input  wire rom_sdo_i,
   output reg  rom_cs_o,
   output reg  rom_data_o
);
   reg                 sclk_q;
   reg [MODE_BITS-1:0] shift_q;
   reg [7:0]           nbits_q;
   reg                 fault_q;
   wire                rise = sclk_i & ~sclk_q;

   always @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sclk_q     <= 1'b0;
         shift_q    <= {MODE_BITS{1'b0}};
         nbits_q    <= 8'h0;
         fault_q    <= 1'b0;
         rom_cs_o   <= 1'b0;
         rom_data_o <= 1'b0;
      end else begin
         sclk_q <= sclk_i;
         if (rise && !cal_rom_select_cmd_i) begin
            // select low with a clock pulse clears the bit count; a latched mode fault clears only on a second such pulse
            fault_q <= 1'b0;
            nbits_q <= 8'h0;
            rom_cs_o <= 1'b0;
         end else if (rise && rom_cs_o) begin
            rom_data_o <= rom_sdo_i;
            if (nbits_q < MODE_BITS) begin
               shift_q <= {shift_q[MODE_BITS-2:0], sdata_in_i};
               nbits_q <= nbits_q + 8'h1;
            end
         end
         if (nbits_q == MODE_BITS && shift_q != legal_mode_i)
            fault_q <= 1'b1;
         rom_cs_o <= cal_rom_select_cmd_i & ~fault_q &
                     ~(nbits_q == MODE_BITS && shift_q != legal_mode_i);
      end
   end
endmodule
`default_nettype wire

// ===== tb/dsf_status_sva.sv
// port assertions for the status flag block
`timescale 1ns/1ps
`default_nettype none
module dsf_status_sva #(
   parameter CAL_CYCLES = 20
) (
   input wire logic        mclk_i,
   input wire logic        rst_b_i,
   input wire logic [4:0]  addr_i,
   input wire logic        wr_i,
   input wire logic        rd_i,
   input wire logic [15:0] rdata_o,
   input wire logic        fifo_full_i,
   input wire logic        fifo_half_i,
   input wire logic        fifo_empty_i,
   input wire logic        adc_converting_i,
   input wire logic        cal_rom_select_cmd_i,
   input wire logic        rom_cs_o,
   input wire logic        out_data_req_o,
   input wire logic        cal_start_o,
   input wire logic        adc_busy_n_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);
   sequence st_rd; rd_i && addr_i == 5'h18; endsequence
   sequence cal_wr; wr_i && addr_i == 5'h06; endsequence
   sequence cal_busy; (!adc_busy_n_o) [*8]; endsequence
   a_full_bit: assert property (st_rd |=> rdata_o[5] == !$past(fifo_full_i))
      else $error("full flag wrong");
   a_half_bit: assert property (st_rd |=> rdata_o[4] == !$past(fifo_half_i))
      else $error("half flag wrong");
   a_empty_bit: assert property (st_rd |=> rdata_o[3] == !$past(fifo_empty_i))
      else $error("empty flag wrong");
   a_desel_bit: assert property (st_rd |=> rdata_o[1] == $past(rom_cs_o))
      else $error("select status wrong");
   a_sel_cmd: assert property (!cal_rom_select_cmd_i [*3] |-> !rom_cs_o)
      else $error("rom selected unasked");
   a_conv_busy: assert property (adc_converting_i [*2] |-> !adc_busy_n_o)
      else $error("busy missing");
   a_busy_read: assert property (rd_i && addr_i == 5'h1a && adc_converting_i
      && $past(adc_converting_i) |=> !rdata_o[0]) else $error("busy read wrong");
   a_cal_pulse: assert property (cal_wr |=> cal_start_o ##1 !cal_start_o)
      else $error("cal pulse wrong");
   a_cal_busy: assert property (cal_wr |-> ##3 cal_busy)
      else $error("cal not busy");
   a_req_full: assert property (fifo_full_i [*2] |-> !out_data_req_o)
      else $error("request while full");
endmodule
bind dsf_status_top dsf_status_sva #(.CAL_CYCLES(CAL_CYCLES)) sva_u (.mclk_i, .rst_b_i,
   .addr_i, .wr_i, .rd_i, .rdata_o, .fifo_full_i, .fifo_half_i, .fifo_empty_i,
   .adc_converting_i, .cal_rom_select_cmd_i, .rom_cs_o, .out_data_req_o, .cal_start_o,
   .adc_busy_n_o);
`default_nettype wire

// ===== tb/dsf_host_model.sv
// host software model driving the register port
`timescale 1ns/1ps
`default_nettype none
module dsf_host_model (
   input  wire logic        mclk_i,
   input  wire logic [15:0] rdata_i,
   output var  logic [4:0]  addr_o,
   output var  logic [15:0] wdata_o,
   output var  logic        wr_o,
   output var  logic        rd_o
);
   initial begin
      addr_o = 5'h00;
      wdata_o = 16'h0000;
      wr_o = 1'b0;
      rd_o = 1'b0;
   end
   // strobes are plain writes, data is whatever the caller passes
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge mclk_i);
      addr_o <= a;
      wdata_o <= d;
      wr_o <= 1'b1;
      @(posedge mclk_i);
      wr_o <= 1'b0;
   endtask
   task automatic rd(input logic [4:0] a, output logic [15:0] d);
      @(posedge mclk_i);
      addr_o <= a;
      rd_o <= 1'b1;
      @(posedge mclk_i);
      rd_o <= 1'b0;
      #1 d = rdata_i;
   endtask
endmodule
`default_nettype wire

// ===== tb/tb.sv
// self-checking bench for the status flag block
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic        mclk_i = 0, rst_b_i = 0, wr, rd, irq, req, cal, busy_n, cs;
   logic [4:0]  addr;
   logic [15:0] wdata, rdata, rv;
   logic        tick = 0, dacw = 0, run = 0, send = 0, full = 0, half = 0;
   logic        empty = 1, cfg = 1, conv = 0, sel = 0;
   logic        sclk = 0, sdi = 0, sdo = 0, rom_e = 0;
   logic [2:0]  lmode = 3'h5;
   int          n_fail = 0, cmp_count = 0, seed = 32'h29ea, tmr_e = 0, done_e = 0;
   always #12.5 mclk_i = ~mclk_i;
   dsf_host_model host_u (.mclk_i, .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
      .wr_o(wr), .rd_o(rd));
   dsf_status_top #(.CAL_CYCLES(20)) dut_u (.mclk_i, .rst_b_i, .addr_i(addr),
      .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .irq_o(irq),
      .timer_tick_i(tick), .dac_write_i(dacw), .seq_running_i(run), .seq_end_i(send),
      .fifo_full_i(full), .fifo_half_i(half), .fifo_empty_i(empty), .cfg_mem_empty_i(cfg),
      .adc_converting_i(conv), .cal_rom_select_cmd_i(sel), .sclk_i(sclk), .sdata_in_i(sdi),
      .legal_mode_i(lmode), .rom_sdo_i(sdo), .rom_cs_o(cs), .out_data_req_o(req),
      .cal_start_o(cal), .adc_busy_n_o(busy_n));
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // bits 2 and 1 depend on the rom guard and are checked apart
   task automatic st();
      host_u.rd(5'h18, rv);
      chk(rv & 16'h00f9, {8'h0, tmr_e[0], done_e[0], ~full, ~half, ~empty, 2'b0, ~cfg});
   endtask
   // one shift clock pulse: high for a cycle, then low for a cycle
   task automatic pulse(input logic b, input logic d);
      @(posedge mclk_i);
      sclk <= 1'b1;
      sdi <= b;
      sdo <= d;
      @(posedge mclk_i);
      sclk <= 1'b0;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      #200000;
      n_fail++;
      tally_and_finish();
   end
   initial begin
      cyc(10);
      rst_b_i <= 1'b1;
      cyc(3);
      st();
      for (int i = 0; i < 12; i++) begin
         @(posedge mclk_i);
         {full, half, empty, cfg, conv} <= 5'($random(seed));
         st();
         host_u.rd(5'h1a, rv);
         chk(rv & 16'h1, {15'h0, ~conv});
      end
      host_u.rd(5'h1e, rv);
      chk(rv, 16'h0);
      $display("flag test done");
      @(posedge mclk_i);
      {full, half, empty, conv} <= 4'h0;
      for (int m = 4; m < 6; m++) begin
         host_u.wr(5'h0a, 16'(m));
         @(posedge mclk_i);
         tick <= 1'b1;
         @(posedge mclk_i);
         tick <= 1'b0;
         tmr_e = 1;
         st();
         if (m == 5) begin
            cyc(1);
            chk({15'h0, req}, 16'h1);
            @(posedge mclk_i);
            full <= 1'b1;
            cyc(3);
            chk({15'h0, req}, 16'h0);
            @(posedge mclk_i);
            full <= 1'b0;
         end
         @(posedge mclk_i);
         dacw <= 1'b1;
         @(posedge mclk_i);
         dacw <= 1'b0;
         tmr_e = (m == 4);
         st();
      end
      host_u.wr(5'h02, 16'($random(seed)));
      tmr_e = 0;
      st();
      $display("timer test done");
      host_u.wr(5'h0e, 16'h0002);
      host_u.wr(5'h0a, 16'h0006);
      for (int k = 0; k < 2; k++) begin
         @(posedge mclk_i);
         run <= 1'b1;
         done_e = 0;
         st();
         @(posedge mclk_i);
         run <= 1'b0;
         send <= 1'b1;
         @(posedge mclk_i);
         send <= 1'b0;
         done_e = 1;
         cyc(3);
         chk({15'h0, irq}, 16'h1);
         st();
         host_u.wr(k ? 5'h02 : 5'h04, 16'($random(seed)));
         cyc(2);
         chk({15'h0, irq}, 16'h0);
      end
      @(posedge mclk_i);
      empty <= 1'b1;
      st();
      @(posedge mclk_i);
      empty <= 1'b0;
      $display("sequence test done");
      host_u.wr(5'h06, 16'($random(seed)));
      cyc(2);
      host_u.rd(5'h1a, rv);
      chk(rv & 16'h1, 16'h0);
      cyc(30);
      host_u.rd(5'h1a, rv);
      chk(rv & 16'h1, 16'h1);
      host_u.rd(5'h18, rv);
      chk(rv & 16'h2, 16'h0);
      $display("calibration test done");
      @(posedge mclk_i);
      sel <= 1'b1;
      cyc(3);
      for (int j = 2; j >= 0; j--) begin
         rom_e = 1'($random(seed));
         pulse(lmode[j], rom_e);
      end
      cyc(4);
      host_u.rd(5'h18, rv);
      chk(rv & 16'h6, {13'h0, rom_e, 2'b10});
      @(posedge mclk_i);
      sel <= 1'b0;
      pulse(1'b0, 1'b0);
      @(posedge mclk_i);
      sel <= 1'b1;
      cyc(3);
      for (int j = 2; j >= 0; j--)
         pulse(~lmode[j], 1'($random(seed)));
      cyc(4);
      host_u.rd(5'h18, rv);
      chk(rv & 16'h2, 16'h0);
      $display("rom test done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
